/* File: inc/flash_ctl_pkg.sv */
// Behaviour
// - control register works only in user mode
// - control bit 0 starts erase or hard lock
// - byte program and read need no start
// - erase status: zero success, one fail
// - enabled pending interrupt aborts running erase
// - unlock key resets to zero
// - only exact key pattern enables user programming
// - 512 sectors of 128 bytes, two address registers
// - low address bits 6 to 0 ignored
// - no user mode on subsystem clock
// - any enabled interrupt request stops user mode
// - masked request does not stop; only enabled requests do
// - erase, program, read, hard lock offered
// - erase lasts at least 10 ms
package flash_ctl_pkg;
  // ----------------------------------------------------------
  // register map (word indices)
  // ----------------------------------------------------------
  localparam logic [2:0] IDX_KEY   = 3'h0;  // flash_unlock_key
  localparam logic [2:0] IDX_CTRL  = 3'h1;  // flash_op_control
  localparam logic [2:0] IDX_SECH  = 3'h2;  // sector_addr_high
  localparam logic [2:0] IDX_SECL  = 3'h3;  // sector_addr_low
  localparam logic [2:0] IDX_STAT  = 3'h4;  // interrupt status
  localparam logic [2:0] IDX_MASK  = 3'h5;  // interrupt mask
  localparam int         ADDR_LSB  = 2;     // word aligned
  // ----------------------------------------------------------
  // field values
  // ----------------------------------------------------------
  localparam logic [7:0] KEY_ENABLE = 8'hA5; // unlock pattern
  localparam logic [7:0] KEY_RESET  = 8'h00;
  localparam logic [3:0] OP_ERASE   = 4'hA;  // sector erase
  localparam logic [3:0] OP_PROGRAM = 4'h5;  // byte program
  localparam logic [3:0] OP_LOCK    = 4'h6;  // hard lock
  localparam logic [3:0] OP_RESET   = 4'h0;
  localparam logic [7:0] SEC_RESET  = 8'h00;
  localparam int         BIT_START  = 0;
  localparam int         BIT_EFAIL  = 3;
  localparam int         OP_LSB     = 4;
  localparam int         IRQ_W      = 3;     // status bits
  localparam int         ST_DONE    = 0;     // erase finished
  localparam int         ST_FAIL    = 1;     // erase aborted
  localparam int         ST_LOCK    = 2;     // hard lock set
  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLK_MHZ       = 50;
  localparam int ERASE_TIME_US = 10000;      // 10 ms
  localparam int ERASE_CYC_DEF = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 24;
  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [0:0] {IDLE, ERASING} seq_type;
  typedef struct packed {
    logic [7:0]       key;       // unlock key
    logic [3:0]       op;        // pending operation
    logic             efail;     // erase status
    logic [7:0]       sech;      // sector high byte
    logic [7:0]       secl;      // sector low byte
    logic [IRQ_W-1:0] stat;      // sticky events
    logic [IRQ_W-1:0] mask;      // event enables
    seq_type          seq;       // sequencer state
    logic [CNT_W-1:0] cnt;       // erase cycles left
    logic [CNT_W-1:0] elapsed;   // erase cycles run
    logic             a_valid;   // data phase pending
    logic             a_write;
    logic [2:0]       a_idx;
    logic [31:0]      rdata;     // bus read data
    logic             abort;     // erase abort pulse
    logic             lock;      // hard lock pulse
    logic             prog;      // byte program pulse
    logic             rd;        // byte read pulse
    logic [15:0]      faddr;     // byte address
    logic [7:0]       fwdata;    // byte to program
    logic             rvalid;    // load data valid
    logic [7:0]       ldata;     // load data
  } state_type;
endpackage

/* File: src/flash_user_program_control.sv */
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
module flash_user_program_control
  import flash_ctl_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC_DEF,
  parameter int IRQ_SRC      = 8
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic [IRQ_SRC-1:0] irq_pending,
  input  wire logic [IRQ_SRC-1:0] irq_enable,
  input  wire logic               subclk_sel,
  input  wire logic               load_valid,
  input  wire logic               load_write,
  input  wire logic [15:0]        load_addr,
  input  wire logic [7:0]         load_wdata,
  output logic                    load_rvalid,
  output logic [7:0]              load_rdata,
  input  wire logic [7:0]         flash_rdata,
  output logic                    flash_erase,
  output logic [8:0]              erase_sector,
  output logic                    flash_hard_lock,
  output logic                    flash_prog,
  output logic                    flash_read,
  output logic [15:0]             flash_addr,
  output logic [7:0]              flash_wdata,
  output logic                    erase_abort,
  output logic                    irq
);
  // ----------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------
  // the erase counter must hold the full erase time
  if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W)) begin : g_bad_cyc
    $error("ERASE_CYCLES out of range");
  end
  // at least one interrupt source is needed
  if (IRQ_SRC < 1) begin : g_bad_src
    $error("IRQ_SRC must be at least 1");
  end

  // erase length in clocks, sized to the counter
  localparam logic [CNT_W-1:0] ERASE_CNT = CNT_W'(ERASE_CYCLES);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // sector index from the two address bytes
  function automatic logic [8:0] sector_of(input logic [7:0] hi,
                                           input logic [7:0] lo);
    sector_of = {hi, lo[7]};
  endfunction

  // operation field of a control byte
  function automatic logic [3:0] op_of(input logic [7:0] b);
    op_of = b[OP_LSB+3:OP_LSB];
  endfunction

  // register read mux
  function automatic logic [31:0] read_mux(input state_type r,
                                           input logic [2:0] idx);
    logic [7:0] v;
    // unused bits read as zero
    v = 8'h00;
    case (idx)
      IDX_KEY:  v = r.key;
      IDX_CTRL: v = {r.op, r.efail, 2'b00, r.seq == ERASING};
      IDX_SECH: v = r.sech;
      IDX_SECL: v = r.secl;
      IDX_STAT: v = {5'h00, r.stat};
      IDX_MASK: v = {5'h00, r.mask};
      default:  v = 8'h00;
    endcase
    read_mux = {24'h000000, v};
  endfunction

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  state_type s;       // registered state
  state_type next_s;  // next state

  logic       key_ok;     // unlock pattern present
  logic       irq_req;    // enabled request raised
  logic       user_mode;  // user program mode live
  logic       take;       // address phase accepted
  logic       wr;         // write data phase
  logic [7:0] wb;         // written byte
  logic [IRQ_W-1:0] ev;   // events this cycle

  // mode qualifiers shared by the bus and the load port
  assign key_ok  = (s.key == KEY_ENABLE);
  assign irq_req = |(irq_pending & irq_enable);
  assign user_mode = key_ok && !subclk_sel && !irq_req;
  assign take = hsel && hready && htrans[1];
  assign wr   = s.a_valid && s.a_write;
  assign wb   = hwdata[7:0];

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    // hold everything, strobes default low
    next_s        = s;
    ev            = '0;
    next_s.abort  = 1'b0;
    next_s.lock   = 1'b0;
    next_s.prog   = 1'b0;
    next_s.rd     = 1'b0;
    next_s.rvalid = 1'b0;
    // bus data phase writes
    if (wr) begin
      // only the low byte lane is stored
      case (s.a_idx)
        IDX_KEY:  next_s.key  = wb;
        IDX_SECH: next_s.sech = wb;
        IDX_SECL: next_s.secl = wb;
        IDX_MASK: next_s.mask = wb[IRQ_W-1:0];
        IDX_CTRL: begin
          // control ignored outside user mode
          if (user_mode && s.seq == IDLE) begin
            next_s.op = op_of(wb);
            if (wb[BIT_START]) begin
              if (op_of(wb) == OP_ERASE) begin
                // erase launch: status reads failed until done
                next_s.seq     = ERASING;
                next_s.cnt     = ERASE_CNT;
                next_s.elapsed = '0;
                next_s.efail   = 1'b1;
              end else if (op_of(wb) == OP_LOCK) begin
                // hard lock: one pulse, event flagged at once
                next_s.lock = 1'b1;
                ev[ST_LOCK] = 1'b1;
              end
            end
          end
        end
        default: begin
          // status write-one clear handled below; unmapped: no stored effect
        end
      endcase
    end
    // erase sequencer
    case (s.seq)
      IDLE: begin
        // nothing to count
      end
      ERASING: begin
        next_s.elapsed = s.elapsed + 1'b1;
        // abort wins over completion in the same cycle
        if (irq_req || subclk_sel) begin
          next_s.seq   = IDLE;
          next_s.abort = 1'b1;
          next_s.efail = 1'b1;
          ev[ST_FAIL]  = 1'b1;
        end else if (s.cnt == CNT_W'(1)) begin
          // last counted cycle: erase complete
          next_s.seq   = IDLE;
          next_s.efail = 1'b0;
          ev[ST_DONE]  = 1'b1;
        end else begin
          // keep counting down
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      default: next_s.seq = IDLE;
    endcase
    // program-memory load: program and read bytes
    if (load_valid && s.seq == IDLE) begin
      next_s.faddr = load_addr;
      if (!load_write) begin
        // byte reads need no key
        next_s.rd = 1'b1;
      end else if (user_mode && s.op == OP_PROGRAM &&
                   load_addr[15:7] == sector_of(s.sech, s.secl)) begin
        // program only inside the loaded sector
        next_s.prog   = 1'b1;
        next_s.fwdata = load_wdata;
      end
    end
    // read data returns the cycle after the read strobe
    if (s.rd) begin
      next_s.rvalid = 1'b1;
      next_s.ldata  = flash_rdata;
    end
    // sticky status: set wins over write-one clear
    if (wr && s.a_idx == IDX_STAT) begin
      next_s.stat = s.stat & ~wb[IRQ_W-1:0];
    end
    next_s.stat = next_s.stat | ev;
    // bus address phase capture, read data from next values
    next_s.a_valid = take;
    if (take) begin
      next_s.a_write = hwrite;
      next_s.a_idx   = haddr[ADDR_LSB+2:ADDR_LSB];
      if (!hwrite) begin
        next_s.rdata = read_mux(next_s, haddr[ADDR_LSB+2:ADDR_LSB]);
      end
    end
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // clear the whole state, then the documented reset values
      s      <= '0;
      s.key  <= KEY_RESET;
      s.op   <= OP_RESET;
      s.sech <= SEC_RESET;
      s.secl <= SEC_RESET;
      s.seq  <= IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  // bus is zero wait and never signals an error
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = s.rdata;
  // array strobes straight from their flip-flops
  assign flash_erase     = (s.seq == ERASING);
  assign erase_sector    = sector_of(s.sech, s.secl);
  assign flash_hard_lock = s.lock;
  assign flash_prog      = s.prog;
  assign flash_read      = s.rd;
  assign flash_addr      = s.faddr;
  assign flash_wdata     = s.fwdata;
  assign load_rvalid     = s.rvalid;
  assign load_rdata      = s.ldata;
  assign erase_abort     = s.abort;
  // level interrupt from sticky status and mask
  assign irq             = |(s.stat & s.mask);

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  logic start_erase;  // erase launch written this cycle
  assign start_erase = wr && s.a_idx == IDX_CTRL && user_mode &&
                       s.seq == IDLE && wb[BIT_START] &&
                       op_of(wb) == OP_ERASE;

  // launch and protection
  property p_start;
    @(posedge hclk) disable iff (!hresetn)
      start_erase |=> flash_erase;
  endproperty
  a_start: assert property (p_start) else $error("erase not started");

  property p_nokey;
    @(posedge hclk) disable iff (!hresetn)
      (!flash_erase && wr && s.a_idx == IDX_CTRL && !key_ok) |=> !flash_erase && !flash_hard_lock;
  endproperty
  a_nokey: assert property (p_nokey) else $error("start taken without key");

  // erase timing and abort
  property p_len;
    @(posedge hclk) disable iff (!hresetn)
      ($fell(flash_erase) && !s.efail) |-> $past(s.elapsed) == ERASE_CNT - 1'b1;
  endproperty
  a_len: assert property (p_len) else $error("erase length wrong");

  property p_abort;
    @(posedge hclk) disable iff (!hresetn)
      (flash_erase && irq_req) |=> erase_abort && !flash_erase && s.efail;
  endproperty
  a_abort: assert property (p_abort) else $error("erase not aborted");

  property p_status;
    @(posedge hclk) disable iff (!hresetn)
      $fell(flash_erase) |-> (s.efail == erase_abort);
  endproperty
  a_status: assert property (p_status) else $error("erase status wrong");

  // clock source, requests and key
  property p_subclk;
    @(posedge hclk) disable iff (!hresetn)
      subclk_sel |=> !flash_prog && !flash_hard_lock;
  endproperty
  a_subclk: assert property (p_subclk) else $error("user mode on subclock");

  property p_irqstop;
    @(posedge hclk) disable iff (!hresetn)
      irq_req |=> !flash_prog;
  endproperty
  a_irqstop: assert property (p_irqstop) else $error("program during request");

  property p_keyprog;
    @(posedge hclk) disable iff (!hresetn)
      flash_prog |-> $past(s.key) == KEY_ENABLE;
  endproperty
  a_keyprog: assert property (p_keyprog) else $error("program without key");

  // sector selection and load port
  property p_sector;
    @(posedge hclk) disable iff (!hresetn)
      ($stable(s.sech) && $stable(s.secl[7])) |-> $stable(erase_sector);
  endproperty
  a_sector: assert property (p_sector) else $error("sector select wrong");

  property p_load;
    @(posedge hclk) disable iff (!hresetn)
      (load_valid && !load_write && !flash_erase) |=> flash_read ##1 load_rvalid;
  endproperty
  a_load: assert property (p_load) else $error("byte read lost");

  // state held while erasing, launch status and abort pulse
  property p_busy;
    @(posedge hclk) disable iff (!hresetn)
      flash_erase |=> !flash_prog && !flash_read;
  endproperty
  a_busy: assert property (p_busy) else $error("load served during erase");

  property p_ctrl_hold;
    @(posedge hclk) disable iff (!hresetn)
      flash_erase |=> $stable(s.op);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed during erase");

  property p_efail;
    @(posedge hclk) disable iff (!hresetn)
      start_erase |=> s.efail;
  endproperty
  a_efail: assert property (p_efail) else $error("erase status not pending");

  property p_abort_pulse;
    @(posedge hclk) disable iff (!hresetn)
      erase_abort |=> !erase_abort;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");

  // hard lock and load port strobes
  property p_lock_key;
    @(posedge hclk) disable iff (!hresetn)
      flash_hard_lock |-> $past(s.key) == KEY_ENABLE;
  endproperty
  a_lock_key: assert property (p_lock_key) else $error("hard lock without key");

  property p_lock_stat;
    @(posedge hclk) disable iff (!hresetn)
      flash_hard_lock |-> s.stat[ST_LOCK];
  endproperty
  a_lock_stat: assert property (p_lock_stat) else $error("hard lock event lost");

  property p_rvalid;
    @(posedge hclk) disable iff (!hresetn)
      load_rvalid |-> $past(flash_read);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("load data without read");

  property p_prog_sector;
    @(posedge hclk) disable iff (!hresetn)
      flash_prog |-> flash_addr[15:7] == $past(erase_sector);
  endproperty
  a_prog_sector: assert property (p_prog_sector) else $error("program outside sector");

  // covers of the main scenarios
  c_done:  cover property (@(posedge hclk) disable iff (!hresetn) $fell(flash_erase) && !s.efail);
  c_abort: cover property (@(posedge hclk) disable iff (!hresetn) erase_abort);
  c_prog:  cover property (@(posedge hclk) disable iff (!hresetn) flash_prog);
  c_irq:   cover property (@(posedge hclk) disable iff (!hresetn) irq);
  c_lock:  cover property (@(posedge hclk) disable iff (!hresetn) flash_hard_lock);
endmodule

/* File: verif/flash_array_model.sv */
`timescale 1ns/1ns
module flash_array_model (
  input  wire logic        hclk,
  input  wire logic        flash_erase,
  input  wire logic [8:0]  erase_sector,
  input  wire logic        erase_abort,
  input  wire logic        flash_prog,
  input  wire logic        flash_read,
  input  wire logic [15:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  output logic [7:0]       flash_rdata
);
  // ----------------------------------------------------------
  // array storage
  // ----------------------------------------------------------
  logic [7:0] mem [0:65535];  // whole program memory
  logic       erase_q;        // erase level one cycle ago
  logic [7:0] last_q;         // last byte driven out
  initial begin
    erase_q = 1'b0;
    last_q  = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  // read data only while read strobe stands, else garbage
  assign flash_rdata = flash_read ? mem[flash_addr] : ~last_q;
  // erase fills a whole 128-byte sector, program clears bits only
  always @(posedge hclk) begin
    erase_q <= flash_erase;
    if (erase_q && !flash_erase && !erase_abort) begin
      for (int i = 0; i < 128; i++) mem[{erase_sector, 7'h00} + i] <= 8'hFF;
    end
    if (flash_prog) mem[flash_addr] <= mem[flash_addr] & flash_wdata;
    if (flash_read) last_q <= mem[flash_addr];
  end
endmodule

/* File: verif/test_flash_user_program_control.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_flash_user_program_control;
  import flash_ctl_pkg::*;
  localparam int EC = 20;  // shortened erase time
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, subclk_sel;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  irq_pending, irq_enable, load_wdata, load_rdata, flash_rdata, flash_wdata;
  logic        load_valid, load_write, load_rvalid, flash_erase, flash_hard_lock;
  logic        flash_prog, flash_read, erase_abort, irq;
  logic [15:0] load_addr, flash_addr;
  logic [8:0]  erase_sector;
  int          fails, num_checks;
  flash_user_program_control #(.ERASE_CYCLES(EC), .IRQ_SRC(8)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq_pending(irq_pending), .irq_enable(irq_enable), .subclk_sel(subclk_sel),
    .load_valid(load_valid), .load_write(load_write), .load_addr(load_addr), .load_wdata(load_wdata),
    .load_rvalid(load_rvalid), .load_rdata(load_rdata), .flash_rdata(flash_rdata),
    .flash_erase(flash_erase), .erase_sector(erase_sector), .flash_hard_lock(flash_hard_lock),
    .flash_prog(flash_prog), .flash_read(flash_read), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .erase_abort(erase_abort), .irq(irq));
  flash_array_model array_u (
    .hclk(hclk), .flash_erase(flash_erase), .erase_sector(erase_sector), .erase_abort(erase_abort),
    .flash_prog(flash_prog), .flash_read(flash_read), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));
  // ----------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------
  always #10 hclk = ~hclk;
  initial begin
    repeat (5000) @(posedge hclk);
    fails++;
    wrap_up();
  end
  // ----------------------------------------------------------
  // bus and load port tasks
  // ----------------------------------------------------------
  task automatic bus(input logic wr_en, input logic [2:0] idx, input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {27'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr_en;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd_chk(input logic [2:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    `CHK(q, {24'h0, exp})
  endtask
  task automatic load(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge hclk);
    load_valid <= 1'b1;
    load_write <= w;
    load_addr  <= a;
    load_wdata <= d;
    @(posedge hclk);
    load_valid <= 1'b0;
    #1;
  endtask
  // start request, then a bounded wait for the erase level
  task automatic go_erase(output logic seen);
    wr(IDX_CTRL, 8'hA1);
    #1;
    for (int i = 0; i < 4 && flash_erase !== 1'b1; i++) begin @(posedge hclk); #1; end
    seen = flash_erase;
  endtask
  // bounded watch for a one-cycle pulse on the abort output
  task automatic see_abort(output logic ab);
    ab = 1'b0;
    repeat (4) begin @(posedge hclk); #1; if (erase_abort === 1'b1) ab = 1'b1; end
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    rd_chk(IDX_KEY, 8'h00);
    rd_chk(IDX_CTRL, 8'h00);
    rd_chk(IDX_SECH, 8'h00);
    rd_chk(IDX_SECL, 8'h00);
    rd_chk(IDX_STAT, 8'h00);
    rd_chk(IDX_MASK, 8'h00);
    rd_chk(3'h6, 8'h00);
    `CHK(irq, 1'b0)
    `CHK(hresp, 1'b0)
    $display("done: reset values");
  endtask
  task automatic t_key;
    logic seen;
    wr(IDX_KEY, 8'hA4);
    go_erase(seen);
    `CHK(seen, 1'b0)
    rd_chk(IDX_CTRL, 8'h00);
    $display("done: wrong key");
  endtask
  task automatic t_erase_ok;
    logic seen;
    int   n;
    wr(IDX_KEY, KEY_ENABLE);
    wr(IDX_SECH, 8'h10);
    wr(IDX_SECL, 8'hFF);
    go_erase(seen);
    `CHK(seen, 1'b1)
    `CHK(erase_sector, 9'h021)
    n = 0;
    // software waits for the erase before touching the sector
    while (flash_erase === 1'b1 && n < 100) begin @(posedge hclk); #1; n++; end
    `CHK(n, EC)
    rd_chk(IDX_CTRL, 8'hA0);
    rd_chk(IDX_STAT, 8'h01);
    wr(IDX_MASK, 8'h03);
    @(posedge hclk); #1;
    `CHK(irq, 1'b1)
    wr(IDX_STAT, 8'h01);
    @(posedge hclk); #1;
    `CHK(irq, 1'b0)
    $display("done: sector erase");
  endtask
  task automatic t_prog;
    wr(IDX_CTRL, 8'h50);
    load(1'b1, 16'h1085, 8'h3C);
    `CHK(flash_prog, 1'b1)
    `CHK(flash_addr, 16'h1085)
    `CHK(flash_wdata, 8'h3C)
    load(1'b0, 16'h1085, 8'h00);
    `CHK(flash_read, 1'b1)
    @(posedge hclk); #1;
    `CHK(load_rvalid, 1'b1)
    `CHK(load_rdata, 8'h3C)
    load(1'b0, 16'h10FF, 8'h00);
    @(posedge hclk); #1;
    `CHK(load_rdata, 8'hFF)
    load(1'b1, 16'h1100, 8'h00);
    `CHK(flash_prog, 1'b0)
    $display("done: byte program and read");
  endtask
  task automatic t_irq_abort;
    logic seen, ab;
    go_erase(seen);
    rd_chk(IDX_CTRL, 8'hA9);
    @(posedge hclk);
    irq_pending <= 8'hFF;
    repeat (3) @(posedge hclk);
    #1;
    `CHK(flash_erase, 1'b1)
    @(posedge hclk);
    irq_enable <= 8'h04;
    see_abort(ab);
    `CHK(ab, 1'b1)
    `CHK(flash_erase, 1'b0)
    @(posedge hclk);
    irq_pending <= 8'h00;
    irq_enable  <= 8'h00;
    rd_chk(IDX_CTRL, 8'hA8);
    rd_chk(IDX_STAT, 8'h02);
    `CHK(irq, 1'b1)
    wr(IDX_STAT, 8'h02);
    $display("done: interrupt abort");
  endtask
  task automatic t_subclk;
    logic seen, ab;
    go_erase(seen);
    `CHK(seen, 1'b1)
    @(posedge hclk);
    subclk_sel <= 1'b1;
    see_abort(ab);
    `CHK(ab, 1'b1)
    go_erase(seen);
    `CHK(seen, 1'b0)
    @(posedge hclk);
    subclk_sel <= 1'b0;
    wr(IDX_STAT, 8'h07);
    $display("done: subsystem clock");
  endtask
  task automatic t_lock;
    logic seen;
    wr(IDX_CTRL, 8'h61);
    seen = 1'b0;
    repeat (4) begin #1; if (flash_hard_lock === 1'b1) seen = 1'b1; @(posedge hclk); end
    `CHK(seen, 1'b1)
    rd_chk(IDX_STAT, 8'h04);
    $display("done: hard lock");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; irq_pending = 8'h00; irq_enable = 8'h00; subclk_sel = 1'b0;
    load_valid = 1'b0; load_write = 1'b0; load_addr = 16'h0000; load_wdata = 8'h00;
    fails = 0; num_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_key();
    t_erase_ok();
    t_prog();
    t_irq_abort();
    t_subclk();
    t_lock();
    wrap_up();
  end
endmodule
